// file: src/ofp_defs.vh
// Constants for the output fault protection register bank
`ifndef OFP_DEFS_VH
`define OFP_DEFS_VH

// ==========================================================
// Command codes
`define OFP_CMD_UV_THRESHOLD     8'h44
`define OFP_CMD_UV_REACTION      8'h45
`define OFP_CMD_OC_THRESHOLD     8'h46
`define OFP_CMD_UC_THRESHOLD     8'h4B

// ==========================================================
// Reaction field positions
`define OFP_REACT_MODE_HI        7
`define OFP_REACT_MODE_LO        6
`define OFP_REACT_RETRY_HI       5
`define OFP_REACT_RETRY_LO       3
`define OFP_REACT_TIME_HI        2
`define OFP_REACT_TIME_LO        0
`define OFP_MODE_DISABLE_RETRY   2'h2
`define OFP_RETRY_NONE           3'h0
`define OFP_RETRY_FOREVER        3'h7

// ==========================================================
// Reset values
`define OFP_RST_UV_THRESHOLD     16'h0000
`define OFP_RST_UV_REACTION      8'h80
`define OFP_RST_OC_THRESHOLD     16'hFFFF
`define OFP_RST_UC_THRESHOLD     16'h0000

// ==========================================================
// Timing
`define OFP_RETRY_STEP_MS        35
`define OFP_CLK_MHZ              200
`define OFP_RETRY_STEP_CYCLES    (`OFP_RETRY_STEP_MS * 1000 * `OFP_CLK_MHZ)

`endif

// file: src/ofp_phase_mon.v
// Per-phase current limit monitor for two phases
`timescale 1ns/1ps

module ofp_phase_mon #(
   parameter ABOVE = 1
) (
   input  wire        core_clk,
   input  wire        rst,
   input  wire [15:0] phase_a_current,
   input  wire [15:0] phase_b_current,
   input  wire [15:0] limit,
   output reg         tripped
);

   wire a_trip;
   wire b_trip;

   // ==========================================================
   // Compare
   // Either phase alone trips; each phase is compared with the limit on its own, no total is formed
   assign a_trip = (ABOVE != 0) ? (phase_a_current > limit) : (phase_a_current < limit);
   assign b_trip = (ABOVE != 0) ? (phase_b_current > limit) : (phase_b_current < limit);

   always @(posedge core_clk) begin
      if (rst) begin
         tripped <= 1'b0;
      end else begin
         tripped <= a_trip | b_trip;
      end
   end

endmodule // ofp_phase_mon

// file: src/ofp_retry_timer.v
// Down-counting retry delay timer
`timescale 1ns/1ps

module ofp_retry_timer (
   input  wire        core_clk,
   input  wire        rst,
   input  wire        start,
   input  wire [31:0] delay_cycles,
   output reg         expired
);

   reg [31:0] remaining;
   reg        running;

   // ==========================================================
   // Count
   always @(posedge core_clk) begin
      if (rst) begin
         remaining <= 32'h00000000;
         running   <= 1'b0;
         expired   <= 1'b0;
      end else begin
         expired <= 1'b0;
         if (start) begin
            remaining <= delay_cycles;
            running   <= 1'b1;
         end else if (running) begin
            if (remaining <= 32'h00000001) begin
               running <= 1'b0;
               expired <= 1'b1;
            end else begin
               remaining <= remaining - 32'h00000001;
            end
         end
      end
   end

endmodule // ofp_retry_timer

// file: src/ofp_top.v
// Output under-voltage, over-current and under-current fault protection
// How it works
// - Output voltage below the unsigned threshold is a fault and drops output good.
// - Any fault pulls the alert line low and sets its status bit.
// - Disable-and-retry code turns output off at once, then follows retry settings.
// - Restart attempts come from the three-bit retry count field.
// - Retry count zero: no restart, output stays off until faults cleared.
// - Retry count seven: retry forever until commanded off, bias lost, other fault.
// - Delay between attempts is (retry time plus one) times 35 ms.
// - Either phase above the over-current limit raises an over-current fault.
// - Either phase below the under-current limit raises an under-current fault.
`timescale 1ns/1ps
`include "ofp_defs.vh"

module ofp_top #(
   parameter [31:0] RETRY_STEP_CYCLES = `OFP_RETRY_STEP_CYCLES
) (
   input  wire        core_clk,
   input  wire        rst,
   input  wire [7:0]  cmd_code,
   input  wire        cmd_write,
   input  wire        cmd_read,
   input  wire        cmd_word,
   input  wire [15:0] cmd_wdata,
   output reg  [15:0] cmd_rdata,
   output reg         cmd_ack,
   output reg         cmd_nack,
   input  wire [15:0] vout_sample,
   input  wire [15:0] phase_a_current,
   input  wire [15:0] phase_b_current,
   input  wire        output_on_cmd,
   input  wire        ramp_done,
   input  wire        bias_ok,
   input  wire        other_fault,
   input  wire        fault_clear,
   output reg         output_drive_en,
   output reg         output_good_flag,
   output reg         alert_line_n_out,
   output reg         alert_line_n_oe,
   output reg         uv_fault_bit,
   output reg         oc_fault_bit,
   output reg         uc_fault_bit
);

   localparam [3:0] ST_OFF   = 4'h1;
   localparam [3:0] ST_RUN   = 4'h2;
   localparam [3:0] ST_WAIT  = 4'h4;
   localparam [3:0] ST_LATCH = 4'h8;

   reg  [15:0] output_undervoltage_fault_threshold;
   reg  [7:0]  output_undervoltage_fault_reaction;
   reg  [15:0] phase_overcurrent_peak_threshold;
   reg  [15:0] phase_undercurrent_peak_threshold;
   reg  [3:0]  state;
   reg  [3:0]  next_state;
   reg  [2:0]  attempts;
   reg         uv_seen;
   reg         start_timer;
   reg         on_meta;
   reg         on_sync;
   reg         bias_meta;
   reg         bias_sync;
   reg         other_meta;
   reg         other_sync;
   reg  [31:0] delay_cycles;
   wire        oc_trip;
   wire        uc_trip;
   wire        timer_expired;
   wire [1:0]  react_mode;
   wire [2:0]  retry_limit;
   wire [2:0]  retry_time;
   wire        uv_now;
   wire        stop_req;
   wire        may_retry;
   wire        cmd_known;
   wire        size_ok;
   wire        cmd_ok;

   assign react_mode  = output_undervoltage_fault_reaction[`OFP_REACT_MODE_HI:`OFP_REACT_MODE_LO];
   assign retry_limit = output_undervoltage_fault_reaction[`OFP_REACT_RETRY_HI:`OFP_REACT_RETRY_LO];
   assign retry_time  = output_undervoltage_fault_reaction[`OFP_REACT_TIME_HI:`OFP_REACT_TIME_LO];

   // ==========================================================
   // Command port
   assign cmd_known = (cmd_code == `OFP_CMD_UV_THRESHOLD) || (cmd_code == `OFP_CMD_UV_REACTION) ||
                      (cmd_code == `OFP_CMD_OC_THRESHOLD) || (cmd_code == `OFP_CMD_UC_THRESHOLD);
   // Wrong transfer size is refused rather than half-applied
   assign size_ok = (cmd_code == `OFP_CMD_UV_REACTION) ? !cmd_word : cmd_word;
   assign cmd_ok  = cmd_known && size_ok;

   // Replies one cycle after the strobe, accepted and refused alike
   always @(posedge core_clk) begin
      if (rst) begin
         cmd_ack  <= 1'b0;
         cmd_nack <= 1'b0;
      end else begin
         cmd_ack  <= (cmd_write | cmd_read) & cmd_ok;
         cmd_nack <= (cmd_write | cmd_read) & !cmd_ok;
      end
   end

   always @(posedge core_clk) begin
      if (rst) begin
         output_undervoltage_fault_threshold <= `OFP_RST_UV_THRESHOLD;
         output_undervoltage_fault_reaction  <= `OFP_RST_UV_REACTION;
         phase_overcurrent_peak_threshold    <= `OFP_RST_OC_THRESHOLD;
         phase_undercurrent_peak_threshold   <= `OFP_RST_UC_THRESHOLD;
      end else if (cmd_write && cmd_ok) begin
         case (cmd_code)
            `OFP_CMD_UV_THRESHOLD: output_undervoltage_fault_threshold <= cmd_wdata;
            `OFP_CMD_UV_REACTION:  output_undervoltage_fault_reaction  <= cmd_wdata[7:0];
            `OFP_CMD_OC_THRESHOLD: phase_overcurrent_peak_threshold    <= cmd_wdata;
            `OFP_CMD_UC_THRESHOLD: phase_undercurrent_peak_threshold   <= cmd_wdata;
            default: ;
         endcase
      end
   end

   // Refused reads return zero so stale data never looks valid
   always @(posedge core_clk) begin
      if (rst) begin
         cmd_rdata <= 16'h0000;
      end else if (cmd_read && cmd_ok) begin
         case (cmd_code)
            `OFP_CMD_UV_THRESHOLD: cmd_rdata <= output_undervoltage_fault_threshold;
            `OFP_CMD_UV_REACTION:  cmd_rdata <= {8'h00, output_undervoltage_fault_reaction};
            `OFP_CMD_OC_THRESHOLD: cmd_rdata <= phase_overcurrent_peak_threshold;
            `OFP_CMD_UC_THRESHOLD: cmd_rdata <= phase_undercurrent_peak_threshold;
            default:               cmd_rdata <= 16'h0000;
         endcase
      end else if (cmd_read) begin
         cmd_rdata <= 16'h0000;
      end
   end

   // ==========================================================
   // Detection
   ofp_phase_mon #(
      .ABOVE (1)
   ) u_oc_mon (
      .core_clk        (core_clk),
      .rst             (rst),
      .phase_a_current (phase_a_current),
      .phase_b_current (phase_b_current),
      .limit           (phase_overcurrent_peak_threshold),
      .tripped         (oc_trip)
   );

   ofp_phase_mon #(
      .ABOVE (0)
   ) u_uc_mon (
      .core_clk        (core_clk),
      .rst             (rst),
      .phase_a_current (phase_a_current),
      .phase_b_current (phase_b_current),
      .limit           (phase_undercurrent_peak_threshold),
      .tripped         (uc_trip)
   );

   // Blanked until the soft start has finished, so a restart cannot trip itself
   assign uv_now = (state == ST_RUN) && ramp_done && (vout_sample < output_undervoltage_fault_threshold);

   always @(posedge core_clk) begin
      if (rst) begin
         uv_seen <= 1'b0;
      end else begin
         uv_seen <= uv_now;
      end
   end

   // ==========================================================
   // Status and alert
   // A new event in the clearing cycle keeps its bit set
   always @(posedge core_clk) begin
      if (rst) begin
         uv_fault_bit     <= 1'b0;
         oc_fault_bit     <= 1'b0;
         uc_fault_bit     <= 1'b0;
         alert_line_n_out <= 1'b0;
         alert_line_n_oe  <= 1'b0;
      end else begin
         uv_fault_bit     <= uv_seen | (uv_fault_bit & !fault_clear);
         oc_fault_bit     <= oc_trip | (oc_fault_bit & !fault_clear);
         uc_fault_bit     <= uc_trip | (uc_fault_bit & !fault_clear);
         alert_line_n_out <= 1'b0;
         alert_line_n_oe  <= uv_seen | oc_trip | uc_trip |
                             ((uv_fault_bit | oc_fault_bit | uc_fault_bit) & !fault_clear);
      end
   end

   // ==========================================================
   // Pin synchronisers
   // Costs two cycles of reaction to a pin, far below any retry delay
   always @(posedge core_clk) begin
      if (rst) begin
         on_meta    <= 1'b0;
         on_sync    <= 1'b0;
         bias_meta  <= 1'b0;
         bias_sync  <= 1'b0;
         other_meta <= 1'b0;
         other_sync <= 1'b0;
      end else begin
         on_meta    <= output_on_cmd;
         on_sync    <= on_meta;
         bias_meta  <= bias_ok;
         bias_sync  <= bias_meta;
         other_meta <= other_fault;
         other_sync <= other_meta;
      end
   end

   // ==========================================================
   // Restart sequencing
   // Product registered to keep the multiplier off the timer load path
   always @(posedge core_clk) begin
      if (rst) begin
         delay_cycles <= 32'h00000000;
      end else begin
         delay_cycles <= ({29'h00000000, retry_time} + 32'h00000001) * RETRY_STEP_CYCLES;
      end
   end

   assign stop_req     = !on_sync || !bias_sync || other_sync;
   assign may_retry    = (retry_limit == `OFP_RETRY_FOREVER) || (attempts < retry_limit);

   ofp_retry_timer u_timer (
      .core_clk     (core_clk),
      .rst          (rst),
      .start        (start_timer),
      .delay_cycles (delay_cycles),
      .expired      (timer_expired)
   );

   always @* begin
      next_state  = state;
      start_timer = 1'b0;
      case (state)
         ST_OFF: begin
            if (!stop_req) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (stop_req) begin
               next_state = ST_OFF;
            end else if (uv_seen && react_mode == `OFP_MODE_DISABLE_RETRY) begin
               if (retry_limit == `OFP_RETRY_NONE) begin
                  next_state = ST_LATCH;
               end else if (may_retry) begin
                  next_state  = ST_WAIT;
                  start_timer = 1'b1;
               end else begin
                  next_state = ST_LATCH;
               end
            end
         end
         ST_WAIT: begin
            if (stop_req) begin
               next_state = ST_OFF;
            end else if (timer_expired) begin
               next_state = ST_RUN;
            end
         end
         ST_LATCH: begin
            if (fault_clear) begin
               next_state = ST_OFF;
            end
         end
         default: begin
            next_state = ST_OFF;
         end
      endcase
   end

   always @(posedge core_clk) begin
      if (rst) begin
         state    <= ST_OFF;
         attempts <= 3'h0;
      end else begin
         state <= next_state;
         if (state == ST_OFF || state == ST_LATCH) begin
            attempts <= 3'h0;
         end else if (start_timer && attempts != 3'h7) begin
            attempts <= attempts + 3'h1;
         end
      end
   end

   // ==========================================================
   // Output control
   always @(posedge core_clk) begin
      if (rst) begin
         output_drive_en  <= 1'b0;
         output_good_flag <= 1'b0;
      end else begin
         // Follows the next state so a fault drops the stage on the same edge
         output_drive_en  <= (next_state == ST_RUN);
         output_good_flag <= (state == ST_RUN) && ramp_done &&
                             (vout_sample >= output_undervoltage_fault_threshold);
      end
   end

endmodule // ofp_top

// file: tb/ofp_checker.sv
// Port assertions for the fault protection block
`timescale 1ns/1ps
module ofp_checker #(
   parameter [31:0] RETRY_STEP_CYCLES = 32'd20
) (
   input wire        core_clk,
   input wire        rst,
   input wire [7:0]  cmd_code,
   input wire        cmd_write,
   input wire        cmd_read,
   input wire        cmd_word,
   input wire [15:0] cmd_wdata,
   input wire [15:0] cmd_rdata,
   input wire        cmd_ack,
   input wire        cmd_nack,
   input wire [15:0] vout_sample,
   input wire [15:0] phase_a_current,
   input wire [15:0] phase_b_current,
   input wire        output_on_cmd,
   input wire        ramp_done,
   input wire        bias_ok,
   input wire        other_fault,
   input wire        fault_clear,
   input wire        output_drive_en,
   input wire        output_good_flag,
   input wire        alert_line_n_out,
   input wire        alert_line_n_oe,
   input wire        uv_fault_bit,
   input wire        oc_fault_bit,
   input wire        uc_fault_bit
);
   // ==========================================================
   // Port relations
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (rst);
   reply_once_a: assert property ((cmd_write || cmd_read) |=> cmd_ack ^ cmd_nack)
      else $error("one reply expected");
   idle_quiet_a: assert property (!(cmd_write || cmd_read) |=> !(cmd_ack || cmd_nack))
      else $error("reply without strobe");
   alert_on_bit_a: assert property ((uv_fault_bit || oc_fault_bit || uc_fault_bit) |-> alert_line_n_oe)
      else $error("fault bit without alert");
   alert_cause_a: assert property (alert_line_n_oe |-> (uv_fault_bit || oc_fault_bit || uc_fault_bit))
      else $error("alert without fault bit");
   // Open drain: only ever pulls low
   alert_level_a: assert property (alert_line_n_oe |-> !alert_line_n_out)
      else $error("alert driven high");
   uv_sticky_a: assert property (uv_fault_bit && !fault_clear |=> uv_fault_bit)
      else $error("status bit lost");
   // Pins pass two synchroniser flops before the state machine sees them
   restart_gate_a: assert property ($rose(output_drive_en) |-> $past(bias_ok, 3) && $past(output_on_cmd, 3))
      else $error("restart without command or bias");
   bias_stop_a: assert property ((!bias_ok) [*4] |-> !output_drive_en)
      else $error("output on without bias");
   other_stop_a: assert property (other_fault [*4] |-> !output_drive_en)
      else $error("output on during other fault");
   good_blank_a: assert property ((!ramp_done) [*2] |-> !output_good_flag)
      else $error("good flag during ramp");
   cover property ($rose(uv_fault_bit));
   cover property ($rose(oc_fault_bit));
   cover property ($rose(output_drive_en));
endmodule // ofp_checker
bind ofp_top ofp_checker #(.RETRY_STEP_CYCLES(RETRY_STEP_CYCLES)) chk_u (.*);

// file: tb/ofp_host.sv
// Host controller model for the command port
`timescale 1ns/1ps
module ofp_host (
   input  wire         core_clk,
   input  wire         cmd_ack,
   input  wire         cmd_nack,
   input  wire  [15:0] cmd_rdata,
   output logic [7:0]  cmd_code = 8'h00,
   output logic        cmd_write = 1'b0,
   output logic        cmd_read = 1'b0,
   output logic        cmd_word = 1'b0,
   output logic [15:0] cmd_wdata = 16'h0000
);
   // ==========================================================
   // One transfer; reply taken mid-cycle while it stands
   task xfer(input [7:0] c, input logic w, wd, input [15:0] d, output logic [15:0] r, output logic acc);
      @(negedge core_clk);
      cmd_code = c;
      cmd_word = wd;
      cmd_wdata = d;
      cmd_write = w;
      cmd_read = !w;
      @(negedge core_clk);
      r = cmd_rdata;
      acc = cmd_ack && !cmd_nack;
      cmd_write = 1'b0;
      cmd_read = 1'b0;
      cmd_wdata = ~d; // Stale data must not look valid
   endtask
endmodule // ofp_host

// file: tb/test_output_uv_oc_uc_fault_protection.sv
// Self-checking bench for the fault protection block
`timescale 1ns/1ps
module test_output_uv_oc_uc_fault_protection;
   localparam STEP = 20;
   logic        core_clk = 0, rst = 1, output_on_cmd = 0, ramp_done = 1;
   logic        bias_ok = 1, other_fault = 0, fault_clear = 0, ok;
   logic        cmd_write, cmd_read, cmd_word, cmd_ack, cmd_nack;
   logic        output_drive_en, output_good_flag, alert_line_n_out;
   logic        alert_line_n_oe, uv_fault_bit, oc_fault_bit, uc_fault_bit;
   logic [7:0]  cmd_code;
   logic [15:0] cmd_wdata, cmd_rdata, rd, vout_sample = 16'h2000;
   logic [15:0] phase_a_current = 16'h0050, phase_b_current = 16'h0050;
   int          num_errors = 0, n_tests = 0, rises, cnt;
   ofp_top #(.RETRY_STEP_CYCLES(STEP)) dut_u (.*);
   ofp_host host_u (.*);
   always #2.5 core_clk = ~core_clk;
   // ==========================================================
   // Helpers
   task chk(input logic [15:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task give_verdict;
      if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task xf(input [7:0] c, input logic w, wd, input [15:0] d, want, input logic acc);
      host_u.xfer(c, w, wd, d, rd, ok);
      chk(ok, acc);
      if (!w) chk(rd, want);
   endtask
   task step(input int n);
      logic p;
      rises = 0;
      repeat (n) begin
         p = output_drive_en;
         @(negedge core_clk);
         rises += (output_drive_en && !p);
      end
   endtask
   task wait_drive(input logic v);
      for (cnt = 0; cnt < 500 && output_drive_en !== v; cnt++) @(negedge core_clk);
      if (cnt == 500) begin
         chk(0, 1);
         give_verdict;
      end
   endtask
   task clear;
      // Detector pipelines drain first, since an event in the clearing cycle wins
      repeat (2) @(negedge core_clk);
      fault_clear = 1;
      @(negedge core_clk);
      fault_clear = 0;
      @(negedge core_clk);
   endtask
   // ==========================================================
   // Scenarios
   task t_regs;
      xf(8'h44, 0, 1, 0, 16'h0000, 1);
      xf(8'h45, 0, 0, 0, 16'h0080, 1);
      xf(8'h46, 0, 1, 0, 16'hFFFF, 1);
      xf(8'h4B, 0, 1, 0, 16'h0000, 1);
      xf(8'h44, 0, 0, 0, 16'h0000, 0);
      xf(8'h45, 1, 1, 16'h0011, 0, 0);
      xf(8'h47, 0, 1, 0, 16'h0000, 0);
      xf(8'h45, 0, 0, 0, 16'h0080, 1);
   endtask
   task t_flags;
      xf(8'h46, 1, 1, 16'h0100, 0, 1);
      xf(8'h4B, 1, 1, 16'h0010, 0, 1);
      xf(8'h44, 1, 1, 16'h1000, 0, 1);
      xf(8'h45, 1, 0, 16'h0000, 0, 1);
      wait_drive(1);
      phase_a_current = 16'h0100;
      phase_b_current = 16'h0010;
      step(4);
      chk({oc_fault_bit, uc_fault_bit, alert_line_n_oe}, 0);
      phase_b_current = 16'h0101;
      step(3);
      chk({oc_fault_bit, uc_fault_bit, alert_line_n_oe}, 3'b101);
      phase_b_current = 16'h0050;
      clear;
      phase_a_current = 16'h000F;
      step(3);
      chk({oc_fault_bit, uc_fault_bit, alert_line_n_oe}, 3'b011);
      phase_a_current = 16'h0050;
      ramp_done = 0;
      vout_sample = 16'h0FFF;
      clear;
      step(3);
      chk({uv_fault_bit, output_good_flag}, 0);
      ramp_done = 1;
      step(3);
      chk({uv_fault_bit, alert_line_n_oe, output_drive_en}, 3'b111);
      vout_sample = 16'h2000;
      clear;
   endtask
   task t_latch;
      xf(8'h45, 1, 0, 16'h0080, 0, 1);
      vout_sample = 16'h0FFF;
      step(3);
      chk({uv_fault_bit, alert_line_n_oe, output_drive_en}, 3'b110);
      step(200);
      chk(rises, 0);
      vout_sample = 16'h1000; // Equal to threshold is not a fault
      clear;
      wait_drive(1);
      step(5);
      chk({uv_fault_bit, alert_line_n_oe, output_good_flag}, 3'b001);
   endtask
   task t_retry;
      xf(8'h45, 1, 0, 16'h0091, 0, 1);
      vout_sample = 16'h0800;
      wait_drive(0);
      wait_drive(1);
      chk(cnt >= 2 * STEP && cnt <= 2 * STEP + 4, 1);
      step(400);
      chk(rises, 1);
      chk(output_drive_en, 0);
      vout_sample = 16'h2000;
      clear;
      wait_drive(1);
   endtask
   task t_forever;
      xf(8'h45, 1, 0, 16'h00B8, 0, 1);
      vout_sample = 16'h0800;
      step(300);
      chk(rises >= 8, 1);
      bias_ok = 0;
      step(4);
      step(300);
      chk(rises, 0);
      chk(output_drive_en, 0);
      bias_ok = 1;
      vout_sample = 16'h2000;
      clear;
      wait_drive(1);
      other_fault = 1;
      step(4);
      chk(output_drive_en, 0);
      other_fault = 0;
      wait_drive(1);
   endtask
   initial begin
      repeat (4) @(negedge core_clk);
      rst = 0;
      output_on_cmd = 1;
      t_regs;
      t_flags;
      t_latch;
      t_retry;
      t_forever;
      give_verdict;
   end
endmodule // test_output_uv_oc_uc_fault_protection
